// ===== logic/ops_defines.svh
/*
   Constants of the two-wire slave of the one-time-programmable
   wiper. Assumes inclusion by its bare name from the design file.
*/
`ifndef OPS_DEFINES_SVH
`define OPS_DEFINES_SVH

`define OPS_ADDR_FIXED  6'h16
`define OPS_BIT_LAST    4'h7
`define OPS_BIT_ACK     4'h8
`define OPS_BIT_FIRST   4'h0
`define OPS_COMMIT_POS  7
`define OPS_CODE_MSB    5
`define OPS_WIPER_RESET 6'h00
`define OPS_SYNC_RESET  3'h0
`define OPS_SYNC_IDLE   3'h7

`endif

// ===== logic/ops_pkg.sv
/*
   Types of the two-wire slave of the one-time-programmable
   wiper. Assumes nothing beyond a SystemVerilog compiler.
*/
package ops_pkg;

   typedef enum logic [2:0] {
      LK_ADDR,
      LK_INSTR,
      LK_WDATA,
      LK_RDATA,
      LK_IDLE
   } ops_link_state_type;

   typedef enum logic [1:0] {
      FR_IDLE,
      FR_START,
      FR_RUN
   } ops_frame_state_type;

   typedef struct packed {
      logic       programmed;
      logic [5:0] code;
   } ops_wiper_type;

endpackage : ops_pkg

// ===== logic/ops_i2c_slave.sv
/*
   Two-wire serial slave of the 64-position one-time-programmable
   wiper: address match, instruction with commit bit, wiper writes
   and wiper reads. The byte engine runs on the serial clock; start
   and stop are found on the system clock from filtered pins.
   Assumes an open-drain data wire resolved outside, a static
   address strap and a serial clock well below the system clock.
*/
`include "ops_defines.svh"

module ops_i2c_slave (
   // System
   input  wire logic       clock,
   input  wire logic       resetn,
   // Serial clock from the master
   input  wire logic       scl,
   // Serial data, open drain
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Address strap
   input  wire logic       address_select_pin,
   // Wiper state
   output logic [5:0]      wiper_setting_latch,
   output logic            otp_programmed,
   output logic            wiper_update
);

   // Filter of three stages; second and third must agree
   function automatic logic pin_filter(input logic [2:0] s,
                                       input logic       cur);
      pin_filter = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   // Clock high on both samples while data moves to the given level
   function automatic logic bus_event(input logic scl_now,
                                      input logic scl_nxt,
                                      input logic sda_now,
                                      input logic sda_nxt,
                                      input logic level);
      bus_event = scl_now & scl_nxt & (sda_now != level) & (sda_nxt == level);
   endfunction

   // System domain

   logic [2:0]                   scl_sync_ff;
   logic [2:0]                   sda_sync_ff;
   logic [2:0]                   adr_sync_ff;
   logic                         scl_flt_ff;
   logic                         sda_flt_ff;
   logic                         adr_flt_ff;
   logic                         nxt_scl_flt;
   logic                         nxt_sda_flt;
   logic                         nxt_adr_flt;
   logic                         start_seen;
   logic                         stop_seen;
   ops_pkg::ops_frame_state_type frame_ff;
   ops_pkg::ops_frame_state_type nxt_frame;
   logic                         link_run_ff;
   logic [2:0]                   upd_sync_ff;
   logic                         upd_agree;
   logic                         upd_seen_ff;
   logic                         upd_edge;
   logic [5:0]                   wiper_out_ff;
   logic                         prog_out_ff;
   logic                         upd_out_ff;
   logic                         sda_out_ff;

   // Link domain

   ops_pkg::ops_link_state_type  state_ff;
   ops_pkg::ops_link_state_type  nxt_state;
   logic [3:0]                   bit_cnt_ff;
   logic [3:0]                   nxt_bit_cnt;
   logic [6:0]                   shift_ff;
   logic                         ack_ff;
   logic                         nxt_ack;
   logic                         commit_ff;
   logic                         nxt_commit;
   logic [1:0]                   adr_lnk_ff;
   ops_pkg::ops_wiper_type       wiper_ff;
   ops_pkg::ops_wiper_type       nxt_wiper;
   logic                         upd_tgl_ff;
   logic                         sda_oe_ff;
   logic                         nxt_sda_oe;
   logic [7:0]                   byte_w;
   logic                         byte_done;
   logic                         ack_slot;
   logic                         addr_hit;
   logic                         wr_take;
   logic [7:0]                   rd_byte;
   logic [2:0]                   rd_idx;
   logic                         rd_bit;

   // Pin filtering
   assign nxt_scl_flt = pin_filter(scl_sync_ff, scl_flt_ff);
   assign nxt_sda_flt = pin_filter(sda_sync_ff, sda_flt_ff);
   assign nxt_adr_flt = pin_filter(adr_sync_ff, adr_flt_ff);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scl_sync_ff <= `OPS_SYNC_IDLE;
         sda_sync_ff <= `OPS_SYNC_IDLE;
         adr_sync_ff <= `OPS_SYNC_RESET;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], scl};
         sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
         adr_sync_ff <= {adr_sync_ff[1:0], address_select_pin};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scl_flt_ff <= 1'b1;
         sda_flt_ff <= 1'b1;
         adr_flt_ff <= 1'b0;
      end else begin
         scl_flt_ff <= nxt_scl_flt;
         sda_flt_ff <= nxt_sda_flt;
         adr_flt_ff <= nxt_adr_flt;
      end
   end

   // Start: data falls while clock high
   assign start_seen = bus_event(scl_flt_ff, nxt_scl_flt,
                                 sda_flt_ff, nxt_sda_flt, 1'b0);
   // Stop: data rises while clock high
   assign stop_seen  = bus_event(scl_flt_ff, nxt_scl_flt,
                                 sda_flt_ff, nxt_sda_flt, 1'b1);

   // Frame tracking; link engine held in reset outside frames
   always_comb begin
      nxt_frame = frame_ff;
      case (frame_ff)
         ops_pkg::FR_IDLE: begin
            if (start_seen) begin
               nxt_frame = ops_pkg::FR_START;
            end
         end
         ops_pkg::FR_START: begin
            if (stop_seen) begin
               nxt_frame = ops_pkg::FR_IDLE;
            end else if (!nxt_scl_flt) begin
               nxt_frame = ops_pkg::FR_RUN;
            end
         end
         ops_pkg::FR_RUN: begin
            if (start_seen) begin
               nxt_frame = ops_pkg::FR_START;
            end else if (stop_seen) begin
               nxt_frame = ops_pkg::FR_IDLE;
            end
         end
         default: begin
            nxt_frame = ops_pkg::FR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         frame_ff    <= ops_pkg::FR_IDLE;
         link_run_ff <= 1'b0;
      end else begin
         frame_ff    <= nxt_frame;
         link_run_ff <= (nxt_frame == ops_pkg::FR_RUN);
      end
   end

   // Wiper update event crossing into the system domain
   // Toggle counts once the second and third stages agree
   assign upd_agree = (upd_sync_ff[1] == upd_sync_ff[2]);
   assign upd_edge  = upd_agree & (upd_sync_ff[2] ^ upd_seen_ff);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         upd_sync_ff <= `OPS_SYNC_RESET;
         upd_seen_ff <= 1'b0;
      end else begin
         upd_sync_ff <= {upd_sync_ff[1:0], upd_tgl_ff};
         if (upd_edge) begin
            upd_seen_ff <= upd_sync_ff[2];
         end
      end
   end

   // Wiper word is stable for many serial clocks after the toggle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wiper_out_ff <= `OPS_WIPER_RESET;
         prog_out_ff  <= 1'b0;
         upd_out_ff   <= 1'b0;
      end else begin
         upd_out_ff <= upd_edge;
         if (upd_edge) begin
            wiper_out_ff <= wiper_ff.code;
            prog_out_ff  <= wiper_ff.programmed;
         end
      end
   end

   // Open-drain pin only ever pulls low
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sda_out_ff <= 1'b0;
      end else begin
         sda_out_ff <= 1'b0;
      end
   end

   // Link byte engine

   assign byte_w    = {shift_ff, sda_in};
   assign byte_done = (bit_cnt_ff == `OPS_BIT_LAST);
   assign ack_slot  = (bit_cnt_ff == `OPS_BIT_ACK);
   assign addr_hit  = (byte_w[7:2] == `OPS_ADDR_FIXED)
                    & (byte_w[1] == adr_lnk_ff[1]);
   assign wr_take   = byte_done & (state_ff == ops_pkg::LK_WDATA)
                    & ~wiper_ff.programmed;
   assign nxt_bit_cnt = ack_slot ? `OPS_BIT_FIRST
                                 : bit_cnt_ff + 4'h1;

   always_comb begin
      nxt_state  = state_ff;
      nxt_ack    = ack_ff;
      nxt_commit = commit_ff;
      case (state_ff)
         ops_pkg::LK_ADDR: begin
            if (byte_done) begin
               nxt_ack = addr_hit;
               if (!addr_hit) begin
                  nxt_state = ops_pkg::LK_IDLE;
               end else if (byte_w[0]) begin
                  nxt_state = ops_pkg::LK_RDATA;
               end else begin
                  nxt_state = ops_pkg::LK_INSTR;
               end
            end
         end
         ops_pkg::LK_INSTR: begin
            if (byte_done) begin
               nxt_ack    = 1'b1;
               nxt_commit = byte_w[`OPS_COMMIT_POS];
               nxt_state  = ops_pkg::LK_WDATA;
            end
         end
         ops_pkg::LK_WDATA: begin
            if (byte_done) begin
               nxt_ack = 1'b1;
            end
         end
         ops_pkg::LK_RDATA: begin
            if (byte_done) begin
               nxt_ack = 1'b0;
            end else if (ack_slot && sda_in) begin
               nxt_state = ops_pkg::LK_IDLE;
            end
         end
         ops_pkg::LK_IDLE: begin
            nxt_ack = 1'b0;
         end
         default: begin
            nxt_state = ops_pkg::LK_IDLE;
            nxt_ack   = 1'b0;
         end
      endcase
   end

   // Per-frame state; cleared by every start and stop
   always_ff @(posedge scl or negedge link_run_ff) begin
      if (!link_run_ff) begin
         state_ff   <= ops_pkg::LK_ADDR;
         bit_cnt_ff <= `OPS_BIT_FIRST;
         shift_ff   <= 7'h00;
         ack_ff     <= 1'b0;
         commit_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff   <= byte_w[6:0];
         ack_ff     <= nxt_ack;
         commit_ff  <= nxt_commit;
      end
   end

   // Address strap, already filtered, brought onto the serial clock
   always_ff @(posedge scl or negedge link_run_ff) begin
      if (!link_run_ff) begin
         adr_lnk_ff <= 2'h0;
      end else begin
         adr_lnk_ff <= {adr_lnk_ff[0], adr_flt_ff};
      end
   end

   // Wiper code and programmed flag survive between frames
   always_comb begin
      nxt_wiper = wiper_ff;
      if (wr_take) begin
         nxt_wiper.code = byte_w[`OPS_CODE_MSB:0];
         if (commit_ff) begin
            nxt_wiper.programmed = 1'b1;
         end
      end
   end

   always_ff @(posedge scl or negedge resetn) begin
      if (!resetn) begin
         wiper_ff   <= {1'b0, `OPS_WIPER_RESET};
         upd_tgl_ff <= 1'b0;
      end else begin
         wiper_ff <= nxt_wiper;
         if (wr_take) begin
            upd_tgl_ff <= ~upd_tgl_ff;
         end
      end
   end

   // Read byte: wiper code, upper bits zero
   assign rd_byte = {2'h0, wiper_ff.code};
   assign rd_idx  = 3'h7 - bit_cnt_ff[2:0];
   assign rd_bit  = rd_byte[rd_idx];

   assign nxt_sda_oe = (ack_slot & ack_ff)
                     | ((state_ff == ops_pkg::LK_RDATA)
                        & ~bit_cnt_ff[3] & ~rd_bit);

   // Data line changes only on the falling serial clock
   always_ff @(negedge scl or negedge link_run_ff) begin
      if (!link_run_ff) begin
         sda_oe_ff <= 1'b0;
      end else begin
         sda_oe_ff <= nxt_sda_oe;
      end
   end

   // Outputs
   assign sda_out             = sda_out_ff;
   assign sda_oe              = sda_oe_ff;
   assign wiper_setting_latch = wiper_out_ff;
   assign otp_programmed      = prog_out_ff;
   assign wiper_update        = upd_out_ff;

endmodule // ops_i2c_slave

// ===== logic/ops_README_unused.sv
/*
   Empty unit: holds no logic of the two-wire slave.
   Assumes nothing of its surroundings.
*/

// ===== verif/ops_i2c_slave_asserts.sv
/*
   Concurrent checks on the ports of the two-wire wiper slave.
   Assumes a bind to the slave; resetn asynchronous, active low.
*/
module ops_i2c_slave_asserts (
   // System
   input wire logic       clock,
   input wire logic       resetn,
   // Link
   input wire logic       scl,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       address_select_pin,
   // Wiper
   input wire logic [5:0] wiper_setting_latch,
   input wire logic       otp_programmed,
   input wire logic       wiper_update
);
   timeunit 1ns;
   timeprecision 10ps;
   property p_oe_rise;
      @(posedge clock) disable iff (!resetn) $rose(sda_oe) |-> !scl;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("pull began with clock high");
   property p_out_low;
      @(posedge clock) disable iff (!resetn) sda_out == 1'b0;
   endproperty
   a_out_low: assert property (p_out_low) else $error("data output not low");
   property p_ack_wire;
      @(posedge scl) disable iff (!resetn) sda_oe |-> !sda_in;
   endproperty
   a_ack_wire: assert property (p_ack_wire) else $error("pull not seen on wire");
   property p_upd_pulse;
      @(posedge clock) disable iff (!resetn) wiper_update |=> !wiper_update;
   endproperty
   a_upd_pulse: assert property (p_upd_pulse) else $error("update longer than one cycle");
   property p_upd_when;
      @(posedge clock) disable iff (!resetn) wiper_update |-> scl && !sda_oe;
   endproperty
   a_upd_when: assert property (p_upd_when) else $error("update outside last data bit");
   property p_chg_cause;
      @(posedge clock) disable iff (!resetn) $changed(wiper_setting_latch) |-> wiper_update;
   endproperty
   a_chg_cause: assert property (p_chg_cause) else $error("wiper moved without update");
   property p_prog_sticky;
      @(posedge clock) disable iff (!resetn) otp_programmed |=> otp_programmed;
   endproperty
   a_prog_sticky: assert property (p_prog_sticky) else $error("programmed flag dropped");
   property p_prog_frozen;
      @(posedge clock) disable iff (!resetn) $past(otp_programmed) |-> $stable(wiper_setting_latch);
   endproperty
   a_prog_frozen: assert property (p_prog_frozen) else $error("wiper moved after commit");
   property p_prog_cause;
      @(posedge clock) disable iff (!resetn) $rose(otp_programmed) |-> wiper_update;
   endproperty
   a_prog_cause: assert property (p_prog_cause) else $error("commit without data byte");
   c_update: cover property (@(posedge clock) disable iff (!resetn) wiper_update);
   c_commit: cover property (@(posedge clock) disable iff (!resetn) $rose(otp_programmed));
   c_pull: cover property (@(posedge scl) disable iff (!resetn) sda_oe);
endmodule // ops_i2c_slave_asserts

bind ops_i2c_slave ops_i2c_slave_asserts chk_u (
   .clock(clock), .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .address_select_pin(address_select_pin),
   .wiper_setting_latch(wiper_setting_latch), .otp_programmed(otp_programmed),
   .wiper_update(wiper_update)
);

// ===== verif/ops_master_model.sv
/*
   Behavioural two-wire bus master: serial clock and open-drain pull.
   Assumes a pull-up on the data wire; the clock idles high.
*/
module ops_master_model (
   // Bus
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 10ps;
   localparam realtime Q = 31.25;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic bit_x(input logic b, output logic r);
      scl = 1'b0;
      #Q sda_pull = ~b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q;
   endtask
   task automatic start_c();
      sda_pull = 1'b0;
      #(2*Q) sda_pull = 1'b1;
      #(2*Q);
   endtask
   // One clock with data left high, ahead of a repeated start
   task automatic rise_c();
      scl = 1'b0;
      #(2*Q) scl = 1'b1;
      #(2*Q);
   endtask
   task automatic stop_c();
      scl = 1'b0;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda_pull = 1'b0;
      #(4*Q);
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(last, r);
   endtask
endmodule // ops_master_model

// ===== verif/tb_top.sv
/*
   Self-checking bench of the two-wire wiper slave.
   Assumes the master model and the bound checker beside it.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 10ps;
   logic       clock;
   logic       resetn;
   logic       pin;
   wire        scl;
   wire        m_pull;
   wire        d_oe;
   wire        sda = ~(m_pull | d_oe);
   wire  [5:0] wiper;
   wire        prog;
   wire        upd;
   int         n_mismatch = 0;
   int         compares = 0;
   int         n_upd = 0;
   logic       prog_e = 1'b0;
   logic       ack_s;
   logic [5:0] w_exp = 6'h00;
   logic [7:0] dq[$];

   ops_i2c_slave dut_u (.clock(clock), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(),
      .sda_oe(d_oe), .address_select_pin(pin), .wiper_setting_latch(wiper),
      .otp_programmed(prog), .wiper_update(upd));
   ops_master_model mm_u (.scl(scl), .sda_pull(m_pull), .sda(sda));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) if (upd === 1'b1) n_upd++;

   function automatic logic [7:0] addr_b(logic p, logic rd);
      return {6'h16, p, rd};
   endfunction
   function automatic logic [7:0] rd_val(logic [5:0] w);
      return {2'h0, w};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Write: address, instruction, then the queued data bytes
   task automatic wr_x(input logic p, input logic [7:0] ins, input logic hit);
      logic a;
      int   u;
      mm_u.start_c();
      mm_u.put(addr_b(p, 1'b0), a);
      check({7'h00, a}, {7'h00, hit});
      mm_u.put(ins, a);
      check({7'h00, a}, {7'h00, hit});
      foreach (dq[i]) begin
         u = n_upd;
         mm_u.put(dq[i], a);
         check({7'h00, a}, {7'h00, hit});
         check(8'(n_upd - u), {7'h00, hit & ~prog_e});
         if (hit && !prog_e) begin
            w_exp = dq[i][5:0];
            prog_e = ins[7];
         end
         check({1'b0, prog, wiper}, {1'b0, prog_e, w_exp});
      end
      mm_u.stop_c();
   endtask
   task automatic rd_x(input logic p, input logic hit, input int n);
      logic       a;
      logic [7:0] v;
      mm_u.start_c();
      mm_u.put(addr_b(p, 1'b1), a);
      check({7'h00, a}, {7'h00, hit});
      for (int k = 1; k <= n; k++) begin
         mm_u.get(k == n, v);
         check(v, hit ? rd_val(w_exp) : 8'hff);
      end
      mm_u.stop_c();
   endtask

   initial begin
      resetn = 1'b0;
      pin = 1'b0;
      void'($urandom(32'hbf63_1ce1));
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      repeat (8) @(posedge clock);
      check({1'b0, prog, wiper}, 8'h00);
      $display("test reset done");
      for (int t = 0; t < 6; t++) begin
         @(posedge clock) pin <= 1'($urandom);
         repeat (8) @(posedge clock);
         dq = {8'hc0, 8'h3f, 8'($urandom)};
         wr_x(pin, {1'b0, 7'($urandom)}, 1'b1);
         dq = {8'($urandom)};
         wr_x(~pin, 8'h00, 1'b0);
         rd_x(pin, 1'b1, 2);
         rd_x(~pin, 1'b0, 1);
         $display("test write read %0d done", t);
      end
      dq = {8'($urandom), 8'h2a};
      wr_x(pin, 8'h80, 1'b1);
      dq = {8'h15};
      wr_x(pin, 8'h00, 1'b1);
      rd_x(pin, 1'b1, 1);
      $display("test commit done");
      mm_u.start_c();
      mm_u.put(addr_b(pin, 1'b0), ack_s);
      check({7'h00, ack_s}, 8'h01);
      mm_u.rise_c();
      rd_x(pin, 1'b1, 1);
      $display("test repeated start done");
      complete_run();
   end
   // Whole run needs about 112 us of bus time
   initial begin
      #200_000;
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      complete_run();
   end
endmodule // tb_top
